// *** inc/ecs_params.svh ***
// Overview of operation
// - Pack eight parity words into one storage word
// - Odd parity bit generated per written word
// - Read parity failure signalled to the coupler
// - Store word selected by 24-bit address
// - Consecutive storage words sit in different banks
// - Bank busy one 3.2 us cycle per selection
// - Four independent bidirectional access channels
// - Channels carry 60-bit words plus control
// - Records of up to eight words, single words
// - Scan channels each record, serve one record
// - Per-channel request, address, direction service registers
// - One word per 100 ns slot
// - Four-bank host: four-word half records, reinitiate
// - Eight-bank host: eight words then 200 ns
// - Larger host: continuous words, no pauses
// - Coupler forwards start address with request
// - Word count is index operand plus constant
// - Count words, advance address per record
// - End-of-transfer pulse when count reached
// - One go strobe per host word read
// - Busy shown in bit 17 while transferring
// - Pending requests served at record boundaries
`ifndef ECS_PARAMS_SVH
`define ECS_PARAMS_SVH

// ============================================================
// Widths
`define ECS_WORD_W 60
`define ECS_LANE_W 61
`define ECS_ADDR_W 24
`define ECS_CNT_W 18
`define ECS_REC_WORDS 8
`define ECS_NCH 4
`define ECS_BUSY_BIT 17
`define ECS_HALF_REC 4

// ============================================================
// Timing
`define ECS_CLK_PS 5000
`define ECS_SLOT_PS 100000
`define ECS_BANK_PS 3200000
`define ECS_PAUSE_PS 200000
`define ECS_SLOT_CYC (`ECS_SLOT_PS / `ECS_CLK_PS)
`define ECS_BANK_CYC ((`ECS_BANK_PS + `ECS_CLK_PS - 1) / `ECS_CLK_PS)
`define ECS_PAUSE_CYC ((`ECS_PAUSE_PS + `ECS_CLK_PS - 1) / `ECS_CLK_PS)

`endif

// *** inc/ecs_pkg.sv ***
package ecs_pkg;
    typedef logic [59:0] ecs_word_t;
    typedef logic [23:0] ecs_addr_t;
    typedef enum logic [1:0] {
        ECS_IDLE = 2'h0,
        ECS_BANK = 2'h1,
        ECS_XFER = 2'h3,
        ECS_DONE = 2'h2
    } ecs_ctl_state_t;
    typedef enum logic [1:0] {
        ECS_C_IDLE = 2'h0,
        ECS_C_REQ = 2'h1,
        ECS_C_PAUSE = 2'h3,
        ECS_C_FIN = 2'h2
    } ecs_cpl_state_t;
    typedef enum logic [1:0] {
        ECS_PACE_A = 2'h0,
        ECS_PACE_B = 2'h1,
        ECS_PACE_C = 2'h2
    } ecs_pace_t;
endpackage

// *** inc/ecs_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ecs_link_if #(parameter int NCH = 4);
    wire logic [NCH-1:0] req;
    wire logic [NCH-1:0][23:0] addr;
    wire logic [NCH-1:0] wr;
    wire logic [NCH-1:0][3:0] len;
    wire logic [NCH-1:0][59:0] wdata;
    wire logic [NCH-1:0] wvalid;
    wire logic [NCH-1:0] take;
    wire logic [59:0] rdata;
    wire logic [NCH-1:0] rvalid;
    wire logic [NCH-1:0] perr;
    wire logic [NCH-1:0] rec_done;
    modport store (input req, addr, wr, len, wdata, wvalid,
                   output take, rdata, rvalid, perr, rec_done);
    modport coupler (output req, addr, wr, len, wdata, wvalid,
                     input take, rdata, rvalid, perr, rec_done);
endinterface
`default_nettype wire

// *** hw/ecs_store_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ecs_params.svh"
module ecs_store_ctrl #(
    parameter int NCH = `ECS_NCH,
    parameter int BANK_W = 2,
    parameter int SW_W = 8,
    parameter int BANK_CYC = `ECS_BANK_CYC,
    parameter int SLOT_CYC = `ECS_SLOT_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    ecs_link_if.store lnk,
    output logic [(1<<BANK_W)-1:0] bank_busy,
    output logic [1:0] cur_ch,
    output logic active
);
    import ecs_pkg::*;

    localparam int NBANK = 1 << BANK_W;
    localparam int LW = `ECS_LANE_W;

    // ============================================================
    // Helpers
    function automatic logic odd_par(input ecs_word_t w);
        odd_par = ~^w;
    endfunction

    function automatic logic [2:0] pick(input logic [NCH-1:0] r, input logic [1:0] last);
        logic [2:0] res;
        logic [1:0] c;
        res = 3'h0;
        for (int i = NCH; i >= 1; i--) begin
            c = 2'((int'(last) + i) % NCH);
            if (r[c]) begin
                res = {1'b1, c};
            end
        end
        pick = res;
    endfunction

    // ============================================================
    // Storage, banked, 488-bit words
    logic [8*LW-1:0] mem [0:(1<<SW_W)-1];
    ecs_ctl_state_t state_reg;
    logic [NCH-1:0] svc_req_reg;
    ecs_addr_t svc_addr_reg [NCH];
    logic [NCH-1:0] svc_wr_reg;
    logic [3:0] svc_len_reg [NCH];
    logic [1:0] ch_reg;
    logic [1:0] last_reg;
    logic [LW-1:0] lane_reg [8];
    logic [2:0] widx_reg;
    logic [3:0] cnt_reg;
    logic [$clog2(SLOT_CYC+1)-1:0] slot_reg;
    logic [NCH-1:0] take_reg;
    logic [NCH-1:0] rvalid_reg;
    logic [NCH-1:0] perr_reg;
    logic [NCH-1:0] done_reg;
    ecs_word_t rdata_reg;
    logic [2:0] sel;
    ecs_addr_t cur_addr;
    logic [SW_W-1:0] cur_sw;
    logic [BANK_W-1:0] cur_bank;
    logic slot_end;
    logic word_go;
    logic [8*LW-1:0] packed_word;

    assign sel = pick(svc_req_reg & ~done_reg, last_reg);
    assign cur_addr = svc_addr_reg[ch_reg];
    assign cur_sw = cur_addr[SW_W+2:3];
    assign cur_bank = cur_addr[BANK_W+2:3];
    assign slot_end = (slot_reg == ($bits(slot_reg))'(SLOT_CYC - 1));
    assign word_go = slot_end && (!svc_wr_reg[ch_reg] || lnk.wvalid[ch_reg]);
    assign cur_ch = ch_reg;
    assign active = (state_reg != ECS_IDLE);

    // ============================================================
    // Link outputs
    assign lnk.take = take_reg;
    assign lnk.rvalid = rvalid_reg;
    assign lnk.perr = perr_reg;
    assign lnk.rec_done = done_reg;
    assign lnk.rdata = rdata_reg;

    // ============================================================
    // Service registers, one set per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_svc
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    svc_req_reg[g] <= 1'b0;
                    svc_addr_reg[g] <= '0;
                    svc_wr_reg[g] <= 1'b0;
                    svc_len_reg[g] <= 4'h0;
                end else if (done_reg[g]) begin
                    svc_req_reg[g] <= 1'b0;
                end else if (!svc_req_reg[g] && lnk.req[g]) begin
                    svc_req_reg[g] <= 1'b1;
                    svc_addr_reg[g] <= lnk.addr[g];
                    svc_wr_reg[g] <= lnk.wr[g];
                    svc_len_reg[g] <= (lnk.len[g] == 4'h0) ? 4'h1 : lnk.len[g];
                end
            end
        end
    endgenerate

    // ============================================================
    // Bank cycle timers
    generate
        for (g = 0; g < NBANK; g++) begin : g_bank
            logic [$clog2(BANK_CYC+1)-1:0] tmr_reg;
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    tmr_reg <= '0;
                end else if (state_reg == ECS_BANK && !bank_busy[g]
                             && cur_bank == BANK_W'(g)) begin
                    tmr_reg <= ($bits(tmr_reg))'(BANK_CYC - 1);
                end else if (tmr_reg != '0) begin
                    tmr_reg <= tmr_reg - 1'b1;
                end
            end
            assign bank_busy[g] = (tmr_reg != '0);
        end
    endgenerate

    // ============================================================
    // Scan and record sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= ECS_IDLE;
            ch_reg <= 2'h0;
            last_reg <= 2'h3;
        end else begin
            unique case (state_reg)
                ECS_IDLE: begin
                    if (sel[2]) begin
                        ch_reg <= sel[1:0];
                        state_reg <= ECS_BANK;
                    end
                end
                ECS_BANK: begin
                    if (!bank_busy[cur_bank]) begin
                        state_reg <= ECS_XFER;
                    end
                end
                ECS_XFER: begin
                    if (word_go && cnt_reg + 4'h1 >= svc_len_reg[ch_reg]) begin
                        state_reg <= ECS_DONE;
                    end
                end
                ECS_DONE: begin
                    last_reg <= ch_reg;
                    state_reg <= ECS_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Word slots
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            slot_reg <= '0;
            cnt_reg <= 4'h0;
            widx_reg <= 3'h0;
        end else if (state_reg != ECS_XFER) begin
            slot_reg <= '0;
            cnt_reg <= 4'h0;
            widx_reg <= cur_addr[2:0];
        end else if (word_go) begin
            slot_reg <= '0;
            cnt_reg <= cnt_reg + 4'h1;
            widx_reg <= widx_reg + 3'h1;
        end else if (!slot_end) begin
            slot_reg <= slot_reg + 1'b1;
        end
    end

    // ============================================================
    // Assembly and disassembly
    generate
        for (g = 0; g < 8; g++) begin : g_lane
            assign packed_word[g*LW +: LW] = lane_reg[g];
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    lane_reg[g] <= '0;
                end else if (state_reg == ECS_BANK) begin
                    lane_reg[g] <= mem[cur_sw][g*LW +: LW];
                end else if (state_reg == ECS_XFER && word_go && svc_wr_reg[ch_reg]
                             && widx_reg == 3'(g)) begin
                    lane_reg[g] <= {odd_par(lnk.wdata[ch_reg]), lnk.wdata[ch_reg]};
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (state_reg == ECS_DONE && svc_wr_reg[ch_reg]) begin
            mem[cur_sw] <= packed_word;
        end
    end

    // ============================================================
    // Channel strobes and read data
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            take_reg <= '0;
            rvalid_reg <= '0;
            perr_reg <= '0;
            done_reg <= '0;
            rdata_reg <= '0;
        end else begin
            take_reg <= '0;
            rvalid_reg <= '0;
            perr_reg <= '0;
            done_reg <= '0;
            if (state_reg == ECS_XFER && word_go) begin
                if (svc_wr_reg[ch_reg]) begin
                    take_reg[ch_reg] <= 1'b1;
                end else begin
                    rdata_reg <= lane_reg[widx_reg][59:0];
                    rvalid_reg[ch_reg] <= 1'b1;
                    perr_reg[ch_reg] <= ~^lane_reg[widx_reg];
                end
            end
            if (state_reg == ECS_DONE) begin
                done_reg[ch_reg] <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/ecs_coupler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ecs_params.svh"
module ecs_coupler #(
    parameter int CH = 0,
    parameter int PAUSE_CYC = `ECS_PAUSE_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    ecs_link_if.coupler lnk,
    input wire logic start,
    input wire ecs_pkg::ecs_addr_t start_addr,
    input wire logic to_store,
    input wire logic [17:0] index_register_operand,
    input wire logic [17:0] k_field,
    input wire ecs_pkg::ecs_pace_t pace,
    output logic cm_go,
    input wire logic cm_wvalid,
    input wire ecs_pkg::ecs_word_t cm_wdata,
    output logic cm_rvalid,
    output ecs_pkg::ecs_word_t cm_rdata,
    output logic parity_err,
    output logic end_xfer,
    output logic [17:0] pp_status
);
    import ecs_pkg::*;

    ecs_cpl_state_t state_reg;
    ecs_addr_t addr_reg;
    logic wr_reg;
    logic [17:0] rem_reg;
    logic [17:0] gos_reg;
    logic [3:0] len_reg;
    logic [3:0] len_next;
    logic [17:0] rem_after;
    logic [7:0] pause_reg;
    logic wfull_reg;
    logic wait_reg;
    ecs_word_t wdata_reg;
    logic [17:0] count;
    logic [3:0] cap;
    logic [3:0] room;
    logic [2:0] lo_next;
    logic [17:0] rem_next;

    assign count = 18'(index_register_operand + k_field);
    assign rem_after = rem_reg - 18'(len_reg);
    assign cap = (pace == ECS_PACE_A) ? 4'(`ECS_HALF_REC) : 4'(`ECS_REC_WORDS);

    // Length of the record that follows the values being loaded
    always_comb begin
        lo_next = addr_reg[2:0];
        rem_next = rem_reg;
        if (state_reg == ECS_C_IDLE) begin
            lo_next = start_addr[2:0];
            rem_next = count;
        end else if (state_reg == ECS_C_REQ && lnk.rec_done[CH]) begin
            lo_next = addr_reg[2:0] + len_reg[2:0];
            rem_next = rem_after;
        end
        room = 4'(`ECS_REC_WORDS) - {1'b0, lo_next};
        len_next = cap;
        if (room < len_next) begin
            len_next = room;
        end
        if (rem_next < 18'(len_next)) begin
            len_next = rem_next[3:0];
        end
    end

    // ============================================================
    // Link drive
    assign lnk.req[CH] = (state_reg == ECS_C_REQ);
    assign lnk.addr[CH] = addr_reg;
    assign lnk.wr[CH] = wr_reg;
    assign lnk.len[CH] = len_reg;
    assign lnk.wdata[CH] = wdata_reg;
    assign lnk.wvalid[CH] = wfull_reg;
    assign pp_status = {(state_reg != ECS_C_IDLE), 17'h0};

    // ============================================================
    // Transfer sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= ECS_C_IDLE;
            addr_reg <= '0;
            wr_reg <= 1'b0;
            rem_reg <= 18'h0;
            len_reg <= 4'h0;
            pause_reg <= 8'h0;
            end_xfer <= 1'b0;
        end else begin
            end_xfer <= 1'b0;
            unique case (state_reg)
                ECS_C_IDLE: begin
                    if (start) begin
                        addr_reg <= start_addr;
                        wr_reg <= to_store;
                        rem_reg <= count;
                        state_reg <= (count == 18'h0) ? ECS_C_FIN : ECS_C_REQ;
                    end
                end
                ECS_C_REQ: begin
                    if (lnk.rec_done[CH]) begin
                        addr_reg <= addr_reg + 24'(len_reg);
                        rem_reg <= rem_after;
                        if (rem_after == 18'h0) begin
                            state_reg <= ECS_C_FIN;
                        end else if (pace == ECS_PACE_B) begin
                            pause_reg <= 8'(PAUSE_CYC - 1);
                            state_reg <= ECS_C_PAUSE;
                        end
                    end
                end
                ECS_C_PAUSE: begin
                    if (pause_reg == 8'h0) begin
                        state_reg <= ECS_C_REQ;
                    end else begin
                        pause_reg <= pause_reg - 8'h1;
                    end
                end
                ECS_C_FIN: begin
                    end_xfer <= 1'b1;
                    state_reg <= ECS_C_IDLE;
                end
            endcase
            if (state_reg != ECS_C_REQ || lnk.rec_done[CH]) begin
                len_reg <= len_next;
            end
        end
    end

    // ============================================================
    // Host memory side
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gos_reg <= 18'h0;
            cm_go <= 1'b0;
            wait_reg <= 1'b0;
            wfull_reg <= 1'b0;
            wdata_reg <= '0;
        end else begin
            cm_go <= 1'b0;
            if (state_reg == ECS_C_IDLE) begin
                gos_reg <= (start && to_store) ? count : 18'h0;
                wfull_reg <= 1'b0;
                wait_reg <= 1'b0;
            end else begin
                if (!wfull_reg && !wait_reg && gos_reg != 18'h0) begin
                    cm_go <= 1'b1;
                    wait_reg <= 1'b1;
                    gos_reg <= gos_reg - 18'h1;
                end
                if (cm_wvalid && wait_reg) begin
                    wdata_reg <= cm_wdata;
                    wfull_reg <= 1'b1;
                    wait_reg <= 1'b0;
                end else if (lnk.take[CH]) begin
                    wfull_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cm_rvalid <= 1'b0;
            cm_rdata <= '0;
            parity_err <= 1'b0;
        end else begin
            cm_rvalid <= lnk.rvalid[CH] && !wr_reg;
            parity_err <= lnk.perr[CH];
            if (lnk.rvalid[CH]) begin
                cm_rdata <= lnk.rdata;
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/ecs_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecs_link_checker #(
    parameter int NCH = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [NCH-1:0] req,
    input wire logic [NCH-1:0][23:0] addr,
    input wire logic [NCH-1:0] wr,
    input wire logic [NCH-1:0][3:0] len,
    input wire logic [NCH-1:0] take,
    input wire logic [NCH-1:0] rvalid,
    input wire logic [NCH-1:0] perr,
    input wire logic [NCH-1:0] rec_done
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic [3:0] wcnt_reg;
    // ========================================
    // Words in current record
    always_ff @(posedge mclk) begin
        if (!rst_n || (|rec_done)) begin
            wcnt_reg <= 4'h0;
        end else if (|(take | rvalid)) begin
            wcnt_reg <= wcnt_reg + 4'h1;
        end
    end
    property p_one_chan;
        $onehot0(take | rvalid) && $onehot0(rec_done);
    endproperty
    a_one_chan: assert property (p_one_chan)
        else $error("two channels served at once");
    property p_rec_max;
        wcnt_reg <= 4'h8;
    endproperty
    a_rec_max: assert property (p_rec_max)
        else $error("record longer than eight words");
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        property p_take_gap;
            take[g] |=> (!take[g]) [*3];
        endproperty
        a_take_gap: assert property (p_take_gap)
            else $error("write words closer than one slot");
        property p_rd_gap;
            rvalid[g] |=> (!rvalid[g]) [*3];
        endproperty
        a_rd_gap: assert property (p_rd_gap)
            else $error("read words closer than one slot");
        property p_perr;
            perr[g] |-> rvalid[g];
        endproperty
        a_perr: assert property (p_perr)
            else $error("parity error without read word");
        property p_hold;
            req[g] && $past(req[g]) && !$past(rec_done[g])
                |-> $stable(addr[g]) && $stable(wr[g]) && $stable(len[g]);
        endproperty
        a_hold: assert property (p_hold)
            else $error("request fields changed mid record");
        property p_span;
            req[g] |-> len[g] != 4'h0 && ({1'b0, addr[g][2:0]} + len[g]) <= 4'h8;
        endproperty
        a_span: assert property (p_span)
            else $error("record leaves its storage word");
        property p_serve;
            $rose(req[g]) |-> ##[1:400] rec_done[g];
        endproperty
        a_serve: assert property (p_serve)
            else $error("channel locked out");
        property p_done;
            rec_done[g] |-> $past(req[g]);
        endproperty
        a_done: assert property (p_done)
            else $error("record done without request");
    end
    c_full: cover property ((|rec_done) && wcnt_reg == 4'h8);
    c_two: cover property (rec_done[0] ##[1:300] rec_done[1]);
    c_read: cover property (|rvalid);
endmodule
`default_nettype wire

// *** verification/extended_core_store_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module extended_core_store_ctrl_tb;
    import ecs_pkg::*;
    typedef struct {int c; ecs_addr_t a; logic [17:0] x; logic [17:0] k; ecs_pace_t p; int mx;}
        ecs_row_t;
    logic mclk, rst_n;
    logic [3:0] start, to_store, cm_wvalid;
    wire logic [3:0] cm_go, cm_rvalid, parity_err, end_xfer;
    ecs_addr_t start_addr [4];
    ecs_addr_t base [4];
    logic [17:0] idx [4];
    logic [17:0] kf [4];
    ecs_pace_t pace [4];
    ecs_word_t cm_wdata [4];
    wire ecs_word_t cm_rdata [4];
    wire logic [17:0] pp [4];
    wire logic active;
    wire logic [1:0] cur_ch;
    wire logic [3:0] bank_busy;
    ecs_word_t rdmem [4][64];
    int gocnt [4], rdcnt [4], endcnt [4], e0 [4], reccnt [4], recmax [4];
    int perrcnt, fails, n_compared;
    ecs_row_t rows [4] = '{'{0, 24'h000010, 18'h5, 18'h3, ECS_PACE_C, 8},
                           '{1, 24'h000023, 18'hA, 18'h3, ECS_PACE_A, 4},
                           '{2, 24'h000040, 18'h10, 18'h4, ECS_PACE_B, 8},
                           '{3, 24'h000077, 18'h0, 18'h1, ECS_PACE_C, 1}};
    ecs_link_if #(.NCH(4)) lnk ();
    ecs_store_ctrl #(.BANK_CYC(8), .SLOT_CYC(4)) u_ecs_store_ctrl (
        .mclk(mclk), .rst_n(rst_n), .lnk(lnk), .bank_busy(bank_busy), .cur_ch(cur_ch),
        .active(active)
    );
    for (genvar i = 0; i < 4; i++) begin : g_cpl
        ecs_coupler #(.CH(i), .PAUSE_CYC(4)) u_ecs_coupler (
            .mclk(mclk), .rst_n(rst_n), .lnk(lnk), .start(start[i]),
            .start_addr(start_addr[i]), .to_store(to_store[i]),
            .index_register_operand(idx[i]), .k_field(kf[i]), .pace(pace[i]),
            .cm_go(cm_go[i]), .cm_wvalid(cm_wvalid[i]), .cm_wdata(cm_wdata[i]),
            .cm_rvalid(cm_rvalid[i]), .cm_rdata(cm_rdata[i]),
            .parity_err(parity_err[i]), .end_xfer(end_xfer[i]), .pp_status(pp[i])
        );
    end
    ecs_link_checker #(.NCH(4)) u_ecs_link_checker (
        .mclk(mclk), .rst_n(rst_n), .req(lnk.req), .addr(lnk.addr), .wr(lnk.wr),
        .len(lnk.len), .take(lnk.take), .rvalid(lnk.rvalid), .perr(lnk.perr),
        .rec_done(lnk.rec_done)
    );
    always #2.5 mclk = ~mclk;
    function automatic ecs_word_t pat(input ecs_addr_t a);
        return {12'h5A3, a, ~a};
    endfunction
    // ========================================
    // Host memory and monitors
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            cm_wvalid[i] <= cm_go[i];
            cm_wdata[i] <= cm_go[i] ? pat(base[i] + 24'(gocnt[i])) : ~cm_wdata[i];
            if (cm_go[i]) gocnt[i] <= gocnt[i] + 1;
            if (cm_rvalid[i]) begin
                rdmem[i][rdcnt[i][5:0]] <= cm_rdata[i];
                rdcnt[i] <= rdcnt[i] + 1;
            end
            if (end_xfer[i]) endcnt[i] <= endcnt[i] + 1;
            if (lnk.rec_done[i]) begin
                reccnt[i] <= 0;
            end else if (lnk.take[i] | lnk.rvalid[i]) begin
                reccnt[i] <= reccnt[i] + 1;
                if (reccnt[i] + 1 > recmax[i]) recmax[i] <= reccnt[i] + 1;
            end
        end
        if (|parity_err) perrcnt <= perrcnt + 1;
    end
    // ========================================
    // Checks and sequences
    task automatic chk(input string nm, input logic [59:0] seen, input logic [59:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic launch(input int c, input ecs_addr_t a, input logic ts,
                          input logic [17:0] x, input logic [17:0] k, input ecs_pace_t p);
        @(posedge mclk);
        start[c] <= 1'b1;
        start_addr[c] <= a;
        to_store[c] <= ts;
        idx[c] <= x;
        kf[c] <= k;
        pace[c] <= p;
        base[c] <= a;
        gocnt[c] <= 0;
        rdcnt[c] <= 0;
        reccnt[c] <= 0;
        recmax[c] <= 0;
        e0[c] = endcnt[c];
        @(posedge mclk);
        start[c] <= 1'b0;
        repeat (2) @(posedge mclk);
        if (x + k != 18'h0) chk("busy", pp[c], 18'h20000);
    endtask
    task automatic fin(input int c, input ecs_addr_t a, input logic ts, input int n, input int mx);
        int t;
        for (t = 0; t < 3000 && endcnt[c] == e0[c]; t++) @(posedge mclk);
        if (t == 3000) begin
            fails++;
            $display("mismatch end_xfer expected 1 seen 0");
            results();
        end
        repeat (3) @(posedge mclk);
        chk("busy_off", pp[c], 18'h0);
        chk("end_count", endcnt[c] - e0[c], 1);
        chk("words", ts ? gocnt[c] : rdcnt[c], n);
        chk("record_max", recmax[c], mx);
        for (int i = 0; i < n; i++) if (!ts) chk("data", rdmem[c][i], pat(a + 24'(i)));
    endtask
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        start = '0;
        to_store = '0;
        cm_wvalid = '0;
        perrcnt = 0;
        fails = 0;
        n_compared = 0;
        for (int i = 0; i < 4; i++) begin
            start_addr[i] = '0;
            base[i] = '0;
            idx[i] = '0;
            kf[i] = '0;
            pace[i] = ECS_PACE_C;
            cm_wdata[i] = '0;
            gocnt[i] = 0;
            rdcnt[i] = 0;
            endcnt[i] = 0;
            reccnt[i] = 0;
            recmax[i] = 0;
        end
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        chk("req_reset", lnk.req, 4'h0);
        chk("pp_reset", pp[0], 18'h0);
        chk("active_reset", active, 1'b0);
        chk("cur_ch_reset", cur_ch, 2'h0);
        chk("bank_reset", bank_busy, 4'h0);
        $display("test reset done");
        foreach (rows[r]) begin
            launch(rows[r].c, rows[r].a, 1'b1, rows[r].x, rows[r].k, rows[r].p);
            fin(rows[r].c, rows[r].a, 1'b1, rows[r].x + rows[r].k, rows[r].mx);
            launch(rows[r].c, rows[r].a, 1'b0, rows[r].x, rows[r].k, rows[r].p);
            fin(rows[r].c, rows[r].a, 1'b0, rows[r].x + rows[r].k, rows[r].mx);
            $display("test row %0d done", r);
        end
        for (int ts = 1; ts >= 0; ts--) begin
            for (int c = 0; c < 4; c++) launch(c, 24'h100 + 24'(32 * c), ts[0], 18'h9, 18'h0, ECS_PACE_C);
            for (int c = 0; c < 4; c++) fin(c, 24'h100 + 24'(32 * c), ts[0], 9, 8);
        end
        $display("test four channels done");
        launch(1, 24'h300, 1'b1, 18'h0, 18'h0, ECS_PACE_A);
        fin(1, 24'h300, 1'b1, 0, 0);
        $display("test zero count done");
        launch(0, 24'h200, 1'b1, 18'h14, 18'h0, ECS_PACE_B);
        repeat (10) @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("req_reset", lnk.req, 4'h0);
        chk("pp_reset", pp[0], 18'h0);
        chk("active_reset", active, 1'b0);
        chk("bank_reset", bank_busy, 4'h0);
        rst_n <= 1'b1;
        launch(3, 24'h208, 1'b1, 18'h1, 18'h0, ECS_PACE_C);
        fin(3, 24'h208, 1'b1, 1, 1);
        chk("parity_err", perrcnt, 0);
        $display("test mid reset done");
        results();
    end
endmodule
`default_nettype wire
